// ==== hw/sadm_core.v ====
/*
 staged alarm delay manager: staged delay, smoke alarm verification and
 two-device zone gating, with an Avalon-MM register slave.
 assumes detector event inputs come from asynchronous pins (synchronised here)
 and keypad strobes are already debounced; one device index per detector.
*/
`timescale 1ns/1ps
`include "sadm_defs.vh"

module sadm_core #(
   parameter NDEV     = 8,                                 // number of detection devices
   parameter TICK_DIV = `SADM_CLK_HZ                       // clock cycles per second
) (
   input  wire            CLK_I,                           // 10 MHz system clock
   input  wire            RESET_N_I,                       // synchronous reset, active low
   input  wire [3:0]      AVS_ADDRESS_I,                   // word address
   input  wire            AVS_READ_I,                      // read strobe
   input  wire            AVS_WRITE_I,                     // write strobe
   input  wire [31:0]     AVS_WRITEDATA_I,                 // write data
   output reg  [31:0]     AVS_READDATA_O,                  // read data
   output wire            AVS_WAITREQUEST_O,               // wait request
   input  wire [NDEV-1:0] DET_ALARM_I,                     // detector alarm level per device
   input  wire            PULL_I,                          // manual pull station active
   input  wire            ACK_KEY_I,                       // acknowledge key level
   input  wire            RESET_KEY_I,                     // panel reset key level
   input  wire            MASS_NOTIFICATION_I,             // mass notification active
   input  wire            SUPERVISORY_I,                   // supervisory condition active
   output reg             ALARM_LED_O,                     // alarm led
   output reg             BUZZER_O,                        // internal buzzer
   output reg             UNACKED_O,                       // new unacknowledged alarm
   output reg             NOTIFY_O,                        // notification and all programmed outputs
   output reg             INITIAL_OUT_O,                   // outputs flagged for initial staged alarm
   output reg             SUPPRESS_OTHERS_O,               // hide other events on display
   output reg  [7:0]      TIME_LEFT_O                      // remaining seconds for display
);

   // ***************************************************************
   // input synchronisers and edge detection
   // ***************************************************************
   localparam NS = NDEV + 5;
   reg  [NS-1:0] sync1_r;
   reg  [NS-1:0] sync2_r;
   reg  [NS-1:0] prev_r;
   wire [NS-1:0] rise = sync2_r & ~prev_r;
   wire [NDEV-1:0] det   = sync2_r[NDEV-1:0];
   wire [NDEV-1:0] det_r = rise[NDEV-1:0];
   wire pull  = sync2_r[NDEV];
   wire ack_p = rise[NDEV+1];
   wire rst_p = rise[NDEV+2];
   wire mn    = sync2_r[NDEV+3];
   wire sup   = sync2_r[NDEV+4];

   // two flops, then a history flop for edges
   always @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         sync1_r <= {NS{1'b0}};
         sync2_r <= {NS{1'b0}};
         prev_r  <= {NS{1'b0}};
      end else begin
         sync1_r <= {SUPERVISORY_I, MASS_NOTIFICATION_I, RESET_KEY_I, ACK_KEY_I, PULL_I, DET_ALARM_I};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // ***************************************************************
   // one-second tick
   // ***************************************************************
   reg [31:0] div_r;
   wire       tick = (div_r == TICK_DIV - 1);
   always @(posedge CLK_I) begin
      if (!RESET_N_I)
         div_r <= 32'h0000_0000;
      else if (tick)
         div_r <= 32'h0000_0000;
      else
         div_r <= div_r + 32'h0000_0001;
   end

   // ***************************************************************
   // register file
   // ***************************************************************
   reg [2:0]      ctrl_r;
   reg [NDEV-1:0] vermask_r;
   reg [NDEV-1:0] pasmask_r;
   reg [NDEV-1:0] multmask_r;
   reg            unlock_r;
   reg            cfg_err_r;
   wire wr = AVS_WRITE_I;
   wire [NDEV-1:0] wd = AVS_WRITEDATA_I[NDEV-1:0];

   reg            rd_done_r;                               // read data already latched

   // reads wait one cycle so the registered read data stands when waitrequest drops
   assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_done_r;

   // writes; verification settings need the unlock and a clean mask
   always @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         ctrl_r     <= 3'h0;
         vermask_r  <= {NDEV{1'b0}};
         pasmask_r  <= {NDEV{1'b0}};
         multmask_r <= {NDEV{1'b0}};
         unlock_r   <= 1'b0;
         cfg_err_r  <= 1'b0;
      end else if (wr) begin
         case (AVS_ADDRESS_I)
            `SADM_REG_CTRL: begin
               ctrl_r[`SADM_CTRL_PAS_EN]  <= AVS_WRITEDATA_I[`SADM_CTRL_PAS_EN];
               ctrl_r[`SADM_CTRL_MULT_EN] <= AVS_WRITEDATA_I[`SADM_CTRL_MULT_EN];
               if (unlock_r && !(AVS_WRITEDATA_I[`SADM_CTRL_VER_SYS] && (|multmask_r)))
                  ctrl_r[`SADM_CTRL_VER_SYS] <= AVS_WRITEDATA_I[`SADM_CTRL_VER_SYS];
               else if (AVS_WRITEDATA_I[`SADM_CTRL_VER_SYS] != ctrl_r[`SADM_CTRL_VER_SYS])
                  cfg_err_r <= 1'b1;
            end
            `SADM_REG_VERMASK: begin
               if (unlock_r && ((wd & multmask_r) == {NDEV{1'b0}}))
                  vermask_r <= wd;
               else
                  cfg_err_r <= 1'b1;
            end
            `SADM_REG_PASMASK:  pasmask_r <= wd;
            `SADM_REG_MULTMASK: begin
               if ((wd & vermask_r) == {NDEV{1'b0}} && !ctrl_r[`SADM_CTRL_VER_SYS])
                  multmask_r <= wd;
               else
                  cfg_err_r <= 1'b1;
            end
            `SADM_REG_PASSKEY:  unlock_r <= (AVS_WRITEDATA_I == `SADM_KEY_VALUE);
            `SADM_REG_ERROR:    cfg_err_r <= 1'b0;
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // alarm sequencer
   // ***************************************************************
   reg [5:0] state_r;
   reg [7:0] cnt_r;
   reg [NDEV-1:0] seen_r;                                  // devices already registered
   reg [5:0] state_nxt;
   reg [7:0] cnt_nxt;

   wire ver_sys = ctrl_r[`SADM_CTRL_VER_SYS];
   wire [NDEV-1:0] ver_dev = ver_sys ? ~multmask_r : vermask_r;
   wire [NDEV-1:0] new_det = det_r & ~seen_r;
   wire multi_hit = ctrl_r[`SADM_CTRL_MULT_EN] && (cnt2(det & multmask_r) >= 2'd2);
   wire direct    = |(new_det & ~ver_dev & ~pasmask_r & ~multmask_r);
   wire pas_det   = ctrl_r[`SADM_CTRL_PAS_EN] && |(new_det & pasmask_r & ~ver_dev);
   wire ver_det   = |(new_det & ver_dev);
   wire expired   = tick && (cnt_r == 8'h01);

   // saturating count of asserted bits, two means enough
   function [1:0] cnt2;
      input [NDEV-1:0] v;
      integer k;
      begin
         cnt2 = 2'd0;
         for (k = 0; k < NDEV; k = k + 1)
            if (v[k] && cnt2 != 2'd2)
               cnt2 = cnt2 + 2'd1;
      end
   endfunction

   // next state
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = (tick && cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
      case (state_r)
         `SADM_ST_IDLE: begin
            if (pull || direct || multi_hit || (!ctrl_r[`SADM_CTRL_PAS_EN] && |(new_det & pasmask_r & ~ver_dev))) begin
               state_nxt = `SADM_ST_FULL;
               cnt_nxt   = 8'h00;
            end else if (pas_det) begin
               state_nxt = `SADM_ST_ACKW;
               cnt_nxt   = `SADM_ACK_SEC;
            end else if (ver_det) begin
               state_nxt = `SADM_ST_RRR;
               cnt_nxt   = `SADM_RRR_SEC;
            end
         end
         `SADM_ST_ACKW: begin
            if (pull || |new_det || multi_hit || expired) begin
               state_nxt = `SADM_ST_FULL;
               cnt_nxt   = 8'h00;
            end else if (ack_p) begin
               state_nxt = `SADM_ST_INVW;
               cnt_nxt   = `SADM_INV_SEC;
            end
         end
         `SADM_ST_INVW: begin
            if (pull || |new_det || multi_hit || expired) begin
               state_nxt = `SADM_ST_FULL;
               cnt_nxt   = 8'h00;
            end else if (rst_p) begin
               state_nxt = `SADM_ST_IDLE;
               cnt_nxt   = 8'h00;
            end
         end
         `SADM_ST_RRR: begin
            if (pull || direct || multi_hit) begin
               state_nxt = `SADM_ST_FULL;
               cnt_nxt   = 8'h00;
            end else if (expired) begin
               if (|(det & ver_dev)) begin
                  state_nxt = `SADM_ST_FULL;
                  cnt_nxt   = 8'h00;
               end else begin
                  state_nxt = `SADM_ST_CONF;
                  cnt_nxt   = `SADM_CONF_SEC;
               end
            end
         end
         `SADM_ST_CONF: begin
            if (pull || |det_r || multi_hit) begin
               state_nxt = `SADM_ST_FULL;
               cnt_nxt   = 8'h00;
            end else if (expired) begin
               state_nxt = `SADM_ST_IDLE;
               cnt_nxt   = 8'h00;
            end
         end
         `SADM_ST_FULL: begin
            cnt_nxt = 8'h00;
            if (rst_p)
               state_nxt = `SADM_ST_IDLE;
         end
         default: begin
            state_nxt = `SADM_ST_IDLE;
            cnt_nxt   = 8'h00;
         end
      endcase
   end

   // state, timer and registered-device memory
   always @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         state_r <= `SADM_ST_IDLE;
         cnt_r   <= 8'h00;
         seen_r  <= {NDEV{1'b0}};
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (state_nxt == `SADM_ST_IDLE)
            seen_r <= {NDEV{1'b0}};
         else if (state_nxt != `SADM_ST_CONF)
            seen_r <= seen_r | det_r;
      end
   end

   // ***************************************************************
   // outputs and read-back
   // ***************************************************************
   reg [21:0] blink_r;
   always @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         blink_r           <= 22'h00_0000;
         rd_done_r         <= 1'b0;
         ALARM_LED_O       <= 1'b0;
         BUZZER_O          <= 1'b0;
         UNACKED_O         <= 1'b0;
         NOTIFY_O          <= 1'b0;
         INITIAL_OUT_O     <= 1'b0;
         SUPPRESS_OTHERS_O <= 1'b0;
         TIME_LEFT_O       <= 8'h00;
         AVS_READDATA_O    <= 32'h0000_0000;
      end else begin
         if (tick)
            blink_r <= blink_r + 22'h00_0001;
         ALARM_LED_O       <= (state_nxt == `SADM_ST_ACKW) ? blink_r[0] :
                              (state_nxt == `SADM_ST_INVW) || (state_nxt == `SADM_ST_FULL);
         BUZZER_O          <= (state_nxt == `SADM_ST_ACKW) || (state_nxt == `SADM_ST_FULL);
         UNACKED_O         <= (state_nxt == `SADM_ST_ACKW);
         NOTIFY_O          <= (state_nxt == `SADM_ST_FULL);
         INITIAL_OUT_O     <= (state_nxt == `SADM_ST_ACKW) || (state_nxt == `SADM_ST_INVW) ||
                              (state_nxt == `SADM_ST_FULL);
         SUPPRESS_OTHERS_O <= (state_nxt != `SADM_ST_IDLE) || mn || sup;
         TIME_LEFT_O       <= cnt_nxt;
         rd_done_r         <= AVS_READ_I && !rd_done_r;                        // one wait state per read
         if (AVS_READ_I && !rd_done_r) begin
            case (AVS_ADDRESS_I)
               `SADM_REG_CTRL:     AVS_READDATA_O <= {29'h0, ctrl_r};
               `SADM_REG_VERMASK:  AVS_READDATA_O <= {{(32-NDEV){1'b0}}, vermask_r};
               `SADM_REG_PASMASK:  AVS_READDATA_O <= {{(32-NDEV){1'b0}}, pasmask_r};
               `SADM_REG_MULTMASK: AVS_READDATA_O <= {{(32-NDEV){1'b0}}, multmask_r};
               `SADM_REG_PASSKEY:  AVS_READDATA_O <= {31'h0, unlock_r};
               `SADM_REG_STATUS:   AVS_READDATA_O <= {26'h0, state_r};
               `SADM_REG_TIME:     AVS_READDATA_O <= {24'h0, cnt_r};
               `SADM_REG_ERROR:    AVS_READDATA_O <= {31'h0, cfg_err_r};
               default:            AVS_READDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // sadm_core

// ==== hw/sadm_defs.vh ====
/*
 header of constants for the staged alarm delay manager: timing, configuration
 register layout and state codes.
 assumes a 10 MHz system clock and Avalon-MM register access with 32-bit data.
*/
// Operation
// - stage one, the acknowledgement window, lasts 15 seconds from alarm registration.
// - stage two, the investigation window, lasts 180 seconds after acknowledge.
// - staged alarm from a staged device is recorded but notification held off.
// - staged alarm flashes alarm LED, buzzer continuous, unacknowledged, stage-one countdown.
// - outputs flagged for initial staged alarm activate when the alarm registers.
// - stage one expiring without acknowledge gives full alarm, all outputs on.
// - acknowledge in stage one loads stage two, LED steady, buzzer off, acknowledged.
// - reset before stage two ends clears alarm, otherwise full alarm follows.
// - any further alarm during staged cycle cancels windows and forces full alarm.
// - pull station during either window aborts sequence, all outputs on at once.
// - staged delay works only when enabled by setting, which also bypasses it.
// - during alarm, mass notification or supervisory, other events are kept off display.
// - verification applies to smoke detectors only, system-wide or per device, never pulls.
// - verification never delays alarm actuation more than 60 seconds in total.
// - alarms from devices not under verification actuate outputs without delay.
// - retard-reset-restart interval is at most 30 seconds.
// - smoke at or above threshold when interval ends gives full alarm.
// - below threshold opens 60 second confirmation window; any detector alarm gives full alarm.
// - changing verification configuration needs password authorisation.
// - outputs may be gated to need two or more automatic devices of one zone.
// - verification is refused on detectors in multi-detector or cross-zone gating.
`ifndef SADM_DEFS_VH
`define SADM_DEFS_VH

// ***************************************************************
// timing
// ***************************************************************
`define SADM_CLK_HZ        10000000
`define SADM_ACK_SEC       8'h0F
`define SADM_INV_SEC       8'hB4
`define SADM_RRR_SEC       8'h1E
`define SADM_CONF_SEC      8'h3C
`define SADM_VER_MAX_SEC   8'h3C

// ***************************************************************
// register offsets (word addresses on AVS_ADDRESS_I, one per 32-bit register)
// ***************************************************************
`define SADM_REG_CTRL      4'h0
`define SADM_REG_VERMASK   4'h1
`define SADM_REG_PASMASK   4'h2
`define SADM_REG_MULTMASK  4'h3
`define SADM_REG_PASSKEY   4'h4
`define SADM_REG_STATUS    4'h5
`define SADM_REG_TIME      4'h6
`define SADM_REG_ERROR     4'h7

// control bits
`define SADM_CTRL_PAS_EN   0
`define SADM_CTRL_VER_SYS  1
`define SADM_CTRL_MULT_EN  2
`define SADM_KEY_VALUE     32'h5A5A_1234

// ***************************************************************
// state codes, one-hot
// ***************************************************************
`define SADM_ST_IDLE       6'h01
`define SADM_ST_ACKW       6'h02
`define SADM_ST_INVW       6'h04
`define SADM_ST_RRR        6'h08
`define SADM_ST_CONF       6'h10
`define SADM_ST_FULL       6'h20

`endif

// ==== bench/sadm_core_asserts.sv ====
/*
 checker for sadm_core: port-level assertions on staging, full alarm and display.
 assumes one clock, a bench that holds key presses for several clocks and a
 TICK_DIV matching the instance it is bound to.
*/
`timescale 1ns/1ps

module sadm_core_asserts #(
   parameter TICK_DIV = 10                        // clock cycles per second
) (
   input logic       CLK_I,                       // system clock
   input logic       RESET_N_I,                   // sync reset, active low
   input logic       PULL_I,                      // pull station level
   input logic       ACK_KEY_I,                   // acknowledge key level
   input logic       RESET_KEY_I,                 // panel reset key level
   input logic       MASS_NOTIFICATION_I,         // mass notification active
   input logic       SUPERVISORY_I,               // supervisory active
   input logic       ALARM_LED_O,                 // alarm led
   input logic       BUZZER_O,                    // buzzer
   input logic       UNACKED_O,                   // unacknowledged alarm
   input logic       NOTIFY_O,                    // full alarm outputs
   input logic       INITIAL_OUT_O,               // initial staged outputs
   input logic       SUPPRESS_OTHERS_O,           // display suppression
   input logic [7:0] TIME_LEFT_O                  // seconds remaining
);
   localparam int ACK_MAX = 16 * TICK_DIV + 4;
   logic [11:0]   unack_cnt_r;
   logic [3:0]    quiet_r;

   // cycles in the ack window, and cycles since the reset key was last down
   always @(posedge CLK_I) begin
      unack_cnt_r <= (UNACKED_O && RESET_N_I) ? unack_cnt_r + 12'h001 : 12'h000;
      quiet_r     <= (RESET_KEY_I || !RESET_N_I) ? 4'h0 : ((quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1);
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);

   // operator steps and the displays they must lead to
   sequence s_ack_press;
      $rose(ACK_KEY_I) && UNACKED_O && !PULL_I;
   endsequence
   sequence s_acked;
      !UNACKED_O && !BUZZER_O && ALARM_LED_O && !NOTIFY_O;
   endsequence
   sequence s_alert;
      (MASS_NOTIFICATION_I || SUPERVISORY_I) [*4];
   endsequence

   a_unack_window: assert property (UNACKED_O |-> BUZZER_O && INITIAL_OUT_O && !NOTIFY_O)
      else $error("ack window outputs wrong");
   a_stage_load: assert property ($rose(UNACKED_O) |-> TIME_LEFT_O == 8'h0F)
      else $error("stage one countdown not loaded");
   a_stage_len: assert property (unack_cnt_r <= ACK_MAX)
      else $error("ack window too long");
   a_ack_steady: assert property (s_ack_press |-> ##[1:6] s_acked)
      else $error("acknowledge not taken");
   a_full_outputs: assert property (NOTIFY_O |-> INITIAL_OUT_O && BUZZER_O && ALARM_LED_O && !UNACKED_O)
      else $error("full alarm outputs incomplete");
   a_full_latch: assert property (NOTIFY_O && quiet_r == 4'hF |=> NOTIFY_O)
      else $error("full alarm dropped without reset");
   a_full_frozen: assert property (NOTIFY_O [*3] |-> $stable(TIME_LEFT_O))
      else $error("timer runs in full alarm");
   a_pull_direct: assert property ($rose(PULL_I) |-> ##[1:6] NOTIFY_O)
      else $error("pull station not direct");
   a_alert_hide: assert property (s_alert |-> SUPPRESS_OTHERS_O)
      else $error("display not suppressed");
   a_time_max: assert property (TIME_LEFT_O <= 8'hB4)
      else $error("time left out of range");
endmodule // sadm_core_asserts

bind sadm_core sadm_core_asserts #(.TICK_DIV(TICK_DIV)) sadm_core_asserts_i (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PULL_I(PULL_I), .ACK_KEY_I(ACK_KEY_I),
   .RESET_KEY_I(RESET_KEY_I), .MASS_NOTIFICATION_I(MASS_NOTIFICATION_I), .SUPERVISORY_I(SUPERVISORY_I),
   .ALARM_LED_O(ALARM_LED_O), .BUZZER_O(BUZZER_O), .UNACKED_O(UNACKED_O), .NOTIFY_O(NOTIFY_O),
   .INITIAL_OUT_O(INITIAL_OUT_O), .SUPPRESS_OTHERS_O(SUPPRESS_OTHERS_O), .TIME_LEFT_O(TIME_LEFT_O));

// ==== bench/sadm_field_model.sv ====
/*
 field model: four detectors, a pull station and the operator keypad.
 assumes one-cycle key requests from the bench; each press is held five clocks.
*/
`timescale 1ns/1ps

module sadm_field_model (
   input  logic       clk_i,                      // system clock
   input  logic [3:0] det_i,                      // wanted detector levels
   input  logic       pull_i,                     // wanted pull level
   input  logic       ack_i,                      // ack press request
   input  logic       rst_i,                      // reset press request
   output logic [3:0] det_o = 4'h0,               // detector lines
   output logic       pull_o = 1'b0,              // pull station line
   output logic       ack_o,                      // ack key level
   output logic       rst_o                       // reset key level
);
   logic [2:0] ack_cnt_r = 3'h0;
   logic [2:0] rst_cnt_r = 3'h0;

   // devices follow the bench one clock late; keys stay down five clocks
   always @(posedge clk_i) begin
      det_o     <= det_i;
      pull_o    <= pull_i;
      ack_cnt_r <= ack_i ? 3'h5 : ((ack_cnt_r != 3'h0) ? ack_cnt_r - 3'h1 : 3'h0);
      rst_cnt_r <= rst_i ? 3'h5 : ((rst_cnt_r != 3'h0) ? rst_cnt_r - 3'h1 : 3'h0);
   end
   assign ack_o = (ack_cnt_r != 3'h0);
   assign rst_o = (rst_cnt_r != 3'h0);
endmodule // sadm_field_model

// ==== bench/staged_alarm_delay_manager_tb_top.sv ====
/*
 testbench for sadm_core: register access, staged delay, verification, gating.
 assumes TICK_DIV of 10 (one second is ten clocks) and the field model.
*/
`timescale 1ns/1ps
`include "sadm_defs.vh"

module staged_alarm_delay_manager_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic        rd_s = 1'b0;
   logic        wr_s = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  det = 4'h0;
   logic        pull = 1'b0;
   logic        ack_c = 1'b0;
   logic        rst_c = 1'b0;
   logic        ms = 1'b0;
   logic        sup = 1'b0;
   logic [31:0] rdata, v;
   logic [3:0]  det_w;
   logic        wreq, pull_w, ack_w, rst_w, led, buz, unack, notify, init_o, supp;
   logic [7:0]  tl;
   int          fail_count = 0;
   int          checks = 0;
   int          cyc_cnt = 0;
   int          n;

   sadm_core #(.NDEV(4), .TICK_DIV(10)) sadm_core_i (
      .CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s),
      .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .DET_ALARM_I(det_w),
      .PULL_I(pull_w), .ACK_KEY_I(ack_w), .RESET_KEY_I(rst_w), .MASS_NOTIFICATION_I(ms),
      .SUPERVISORY_I(sup), .ALARM_LED_O(led), .BUZZER_O(buz), .UNACKED_O(unack), .NOTIFY_O(notify),
      .INITIAL_OUT_O(init_o), .SUPPRESS_OTHERS_O(supp), .TIME_LEFT_O(tl));
   sadm_field_model sadm_field_model_i (.clk_i(clk), .det_i(det), .pull_i(pull), .ack_i(ack_c),
      .rst_i(rst_c), .det_o(det_w), .pull_o(pull_w), .ack_o(ack_w), .rst_o(rst_w));

   // 10 MHz clock and a cycle ceiling against hangs
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      d = rdata;
      rd_s <= 1'b0;
   endtask
   task automatic rck(input logic [3:0] a, input logic [31:0] e, input string nm);
      rd(a, v);
      chk(nm, v, e);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic setd(input logic [3:0] d, input logic p);
      @(posedge clk);
      det <= d;
      pull <= p;
   endtask
   task automatic key(input logic is_rst);
      @(posedge clk);
      rst_c <= is_rst;
      ack_c <= ~is_rst;
      @(posedge clk);
      rst_c <= 1'b0;
      ack_c <= 1'b0;
   endtask
   // counts clocks until unack (or notify) rises, with a bound
   task automatic waitfor(input logic on_notify, output int k);
      k = 0;
      @(negedge clk);
      while ((on_notify ? notify : unack) !== 1'b1 && k < 4000) begin
         @(negedge clk);
         k++;
      end
   endtask
   task automatic clr();
      setd(4'h0, 1'b0);
      key(1'b1);
      cyc(15);
      rck(`SADM_REG_STATUS, 32'h1, "idle");
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_regs();
      rck(`SADM_REG_STATUS, 32'h1, "st_reset");
      rck(`SADM_REG_TIME, 32'h0, "time_reset");
      wr(`SADM_REG_CTRL, 32'h7);
      rck(`SADM_REG_CTRL, 32'h5, "ctrl");
      rck(4'h8, 32'h0, "unmapped");
      wr(`SADM_REG_VERMASK, 32'h1);
      rd(`SADM_REG_ERROR, v);
      chk("locked", v != 32'h0, 32'h1);
      rck(`SADM_REG_VERMASK, 32'h0, "locked_mask");
      wr(`SADM_REG_ERROR, 32'h0);
      rck(`SADM_REG_ERROR, 32'h0, "err_clr");
      wr(`SADM_REG_CTRL, 32'h1);
      wr(`SADM_REG_PASMASK, 32'h1);
   endtask
   task automatic t_stage();
      setd(4'h1, 1'b0);
      waitfor(1'b0, n);
      chk("held", {notify, init_o, buz, tl}, {3'h3, 8'h0F});
      waitfor(1'b1, n);
      chk("ack_exp", n >= 138 && n <= 160, 32'h1);
      clr();
      setd(4'h1, 1'b0);
      waitfor(1'b0, n);
      key(1'b0);
      cyc(8);
      chk("acked", {unack, buz, led}, 32'h1);
      chk("inv_load", tl >= 8'hB3, 32'h1);
      rck(`SADM_REG_STATUS, 32'h4, "inv");
      waitfor(1'b1, n);
      chk("inv_exp", n >= 1770 && n <= 1805, 32'h1);
      clr();
   endtask
   task automatic t_abort();
      for (int k = 0; k < 4; k++) begin
         setd(4'h1, 1'b0);
         waitfor(1'b0, n);
         if (k[0]) key(1'b0);
         cyc(10);
         if (k[1]) setd(4'h1, 1'b1);
         else setd(4'h3, 1'b0);
         waitfor(1'b1, n);
         chk("abort", n <= 8, 32'h1);
         clr();
      end
   endtask
   task automatic t_plain();
      wr(`SADM_REG_CTRL, 32'h0);
      setd(4'h1, 1'b0);
      waitfor(1'b1, n);
      chk("direct", {n <= 8, unack}, 32'h2);
      clr();
      wr(`SADM_REG_PASSKEY, `SADM_KEY_VALUE);
      wr(`SADM_REG_VERMASK, 32'h1);
      setd(4'h1, 1'b0);
      waitfor(1'b1, n);
      chk("retard", n >= 290 && n <= 315, 32'h1);
      clr();
      setd(4'h1, 1'b0);
      cyc(5);
      setd(4'h0, 1'b0);
      cyc(330);
      rck(`SADM_REG_STATUS, 32'h10, "confirm");
      setd(4'h2, 1'b0);
      waitfor(1'b1, n);
      chk("conf_alarm", n <= 8, 32'h1);
      clr();
   endtask
   task automatic t_multi();
      wr(`SADM_REG_PASSKEY, `SADM_KEY_VALUE);
      wr(`SADM_REG_VERMASK, 32'h0);
      wr(`SADM_REG_PASMASK, 32'h0);
      wr(`SADM_REG_CTRL, 32'h4);
      wr(`SADM_REG_MULTMASK, 32'h3);
      setd(4'h1, 1'b0);
      cyc(20);
      chk("one_dev", notify, 32'h0);
      setd(4'h3, 1'b0);
      waitfor(1'b1, n);
      chk("two_dev", n <= 8, 32'h1);
      clr();
      wr(`SADM_REG_PASSKEY, `SADM_KEY_VALUE);
      wr(`SADM_REG_VERMASK, 32'h1);
      rd(`SADM_REG_ERROR, v);
      chk("conflict", v != 32'h0, 32'h1);
      rck(`SADM_REG_VERMASK, 32'h0, "conflict_mask");
      @(posedge clk);
      ms <= 1'b1;
      cyc(6);
      chk("mass", supp, 32'h1);
      @(posedge clk);
      ms <= 1'b0;
      sup <= 1'b1;
      cyc(6);
      chk("super", supp, 32'h1);
   endtask

   task automatic end_of_test();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // reset for three clocks, then the scenarios in turn
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_stage();
      t_abort();
      t_plain();
      t_multi();
      end_of_test();
   end
endmodule // staged_alarm_delay_manager_tb_top
